// ### design/clock_divider.sv
/*
 * One clock source selector with a power-of-two prescaler and a ready flag.
 * Assumes the three source levels are synchronous to the system clock and
 * slower than half of it, so each source edge is seen.
 */
`timescale 1ns/1ps
module clock_divider (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic [2:0]                    src_lvl_in,
  input  wire logic [clock_select_pkg::CFG_W-1:0] cfg_in,
  input  wire logic                          restart_in,
  output logic                               clk_out,
  output logic                               ready_out
);
  import clock_select_pkg::*;

  logic [1:0] sel;
  logic [2:0] prescale;
  logic       src_lvl;
  logic       reserved;
  logic       rise;
  logic       prev_r;
  logic [5:0] edge_cnt_r;
  logic [1:0] settle_r;

  assign sel      = cfg_in[SOURCE_SEL_LSB +: SOURCE_SEL_W];
  assign prescale = cfg_in[PRESCALE_LSB +: PRESCALE_W];

  // Source pick, reserved code gives no clock
  always_comb begin
    case (sel)
      SRC_SLOW: src_lvl = src_lvl_in[0];
      SRC_MAIN: src_lvl = src_lvl_in[1];
      SRC_PLL:  src_lvl = src_lvl_in[2];
      default:  src_lvl = 1'b0;
    endcase
  end

  assign reserved = (sel == SRC_RESERVED) || (prescale == PRESCALE_RESERVED);
  assign rise     = src_lvl & ~prev_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= src_lvl;
    end
  end

  // Divide by two to the power of the code
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      edge_cnt_r <= 6'h00;
      clk_out    <= 1'b0;
    end else begin
      edge_cnt_r <= restart_in ? 6'h00 : (edge_cnt_r + {5'h00, rise});
      if (reserved) begin
        clk_out <= 1'b0;
      end else if (prescale == 3'h0) begin
        clk_out <= src_lvl;
      end else begin
        clk_out <= edge_cnt_r[3'(prescale - 3'h1)];
      end
    end
  end

  // Ready after a few edges of the new source
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settle_r  <= 2'h0;
      ready_out <= 1'b0;
    end else begin
      if (restart_in) begin
        settle_r <= 2'h0;
      end else if (rise && (settle_r != SETTLE_EDGES)) begin
        settle_r <= settle_r + 2'h1;
      end
      ready_out <= !restart_in && !reserved && (settle_r == SETTLE_EDGES);
    end
  end

endmodule : clock_divider

// ### design/clock_select_pkg.sv
/*
 * Shared constants for the clock select, status and interrupt block:
 * register offsets, field positions, status bit positions, source codes.
 * Assumes a byte-addressed register port with 32-bit data words.
 */
package clock_select_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int NUM_PROG  = 3;
  localparam int NUM_DIV   = NUM_PROG + 1;
  localparam int NUM_WAKE  = 16;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_PLL_CONFIG           = 8'h2c;
  localparam logic [7:0] OFF_MASTER_CLOCK_CONFIG  = 8'h30;
  localparam logic [7:0] OFF_PROG_CLOCK_CONFIG0   = 8'h40;
  localparam logic [7:0] OFF_PROG_CLOCK_STEP      = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE           = 8'h60;
  localparam logic [7:0] OFF_IRQ_DISABLE          = 8'h64;
  localparam logic [7:0] OFF_CLOCK_STATUS         = 8'h68;
  localparam logic [7:0] OFF_IRQ_MASK_STATE       = 8'h6c;
  localparam logic [7:0] OFF_FAST_STARTUP_ENABLES = 8'h70;
  localparam logic [7:0] OFF_READY_EVENTS         = 8'h74;

  // ****************************************************************
  // Clock config fields
  // ****************************************************************
  localparam int SOURCE_SEL_LSB = 0;
  localparam int SOURCE_SEL_W   = 2;
  localparam int PRESCALE_LSB   = 2;
  localparam int PRESCALE_W     = 3;
  localparam int CFG_W          = SOURCE_SEL_W + PRESCALE_W;

  typedef enum logic [1:0] {
    SRC_SLOW     = 2'h0,
    SRC_MAIN     = 2'h1,
    SRC_PLL      = 2'h2,
    SRC_RESERVED = 2'h3
  } clock_source_t;

  localparam logic [2:0]       PRESCALE_RESERVED = 3'h7;
  localparam logic [CFG_W-1:0] CFG_RESET         = 5'h00;
  localparam logic [1:0]       SETTLE_EDGES      = 2'h2;

  // ****************************************************************
  // PLL settle count
  // ****************************************************************
  localparam int PLL_COUNT_LSB   = 8;
  localparam int PLL_COUNT_W     = 6;
  localparam int PLL_COUNT_SHIFT = 3;
  localparam int PLL_WAIT_W      = PLL_COUNT_W + PLL_COUNT_SHIFT;

  typedef enum logic [1:0] {PLL_IDLE, PLL_COUNTING, PLL_LOCKED} pll_state_t;

  // ****************************************************************
  // Status and interrupt bit positions
  // ****************************************************************
  localparam int BIT_MAIN_READY    = 0;
  localparam int BIT_PLL_LOCK      = 1;
  localparam int BIT_MASTER_READY  = 3;
  localparam int BIT_PROG_READY0   = 8;
  localparam int BIT_MAIN_SEL_DONE = 16;

  localparam logic [31:0] IRQ_SRC_MASK = 32'h0000_070b;
  localparam logic [31:0] STATUS_MASK  = 32'h0001_070b;
  localparam logic [31:0] FAST_MASK    = 32'h0000_ffff;

endpackage : clock_select_pkg

// ### design/clock_select_status_irq.sv
/*
 * Register side of the clock controller: master and programmable clock
 * selection, PLL lock timing, ready status, interrupt enables and the
 * fast start wake-up enables.
 * Assumes a register master that issues single-cycle strobes and takes
 * read data in the cycle after the read strobe.
 */
`timescale 1ns/1ps

// What this block does
// - The master source field picks slow clock, main clock or PLL clock; code 3 is unused.
// - The master prescaler divides the chosen source by two to the power of codes 0 to 6.
// - Every programmable clock has its own source field with the same encoding.
// - Every programmable clock has its own prescaler dividing by 1 to 64; code 7 is unused.
// - A one written to the enable register turns that interrupt source on; zeros do nothing.
// - A one written to the disable register turns that interrupt source off; zeros do nothing.
// - The mask register reads zero for an enabled source and one for a disabled source.
// - Status bit 0 shows whether the main clock is ready.
// - Status bit 1 shows whether the PLL is locked.
// - Status bit 3 shows whether the master clock is ready.
// - Status bits 8 to 10 show whether programmable clocks 0 to 2 are ready.
// - Status bit 16 is zero while main clock selection is in progress, and at reset.
// - Each of sixteen fast start enables lets its wake-up input raise a fast restart.
// - PLL lock is set only after the programmed count times eight slow clock cycles.
module clock_select_status_irq (
  input  wire logic                                CLK_SYS_IN,
  input  wire logic                                RESET_N_IN,
  input  wire logic [clock_select_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [clock_select_pkg::DATA_W-1:0] REG_WDATA_IN,
  input  wire logic                                REG_WR_IN,
  input  wire logic                                REG_RD_IN,
  output logic      [clock_select_pkg::DATA_W-1:0] REG_RDATA_OUT,
  input  wire logic                                SLOW_CLK_IN,
  input  wire logic                                MAIN_CLK_IN,
  input  wire logic                                PLL_CLK_IN,
  input  wire logic                                MAIN_CLOCK_READY_IN,
  input  wire logic                                MAIN_SELECTION_DONE_IN,
  input  wire logic [clock_select_pkg::NUM_WAKE-1:0] WAKE_IN,
  output logic                                     MASTER_CLK_OUT,
  output logic      [clock_select_pkg::NUM_PROG-1:0] PROG_CLOCK_OUTPUT_OUT,
  output logic                                     FAST_RESTART_OUT,
  output logic                                     IRQ_OUT
);
  import clock_select_pkg::*;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [7:0] cfg_offset(input int idx);
    if (idx == 0) begin
      cfg_offset = OFF_MASTER_CLOCK_CONFIG;
    end else begin
      cfg_offset = OFF_PROG_CLOCK_CONFIG0 + 8'(OFF_PROG_CLOCK_STEP * (idx - 1));
    end
  endfunction : cfg_offset

  function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                  input logic [7:0] off);
    wr_hit = wr && (addr == off);
  endfunction : wr_hit

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [CFG_W-1:0]       clk_cfg_r [0:NUM_DIV-1];
  logic [NUM_DIV-1:0]     cfg_wr;
  logic [NUM_DIV-1:0]     div_clk;
  logic [NUM_DIV-1:0]     div_ready;
  logic [2:0]             src_lvl;
  logic [PLL_COUNT_W-1:0] pll_count_r;
  logic [PLL_WAIT_W-1:0]  pll_wait_r;
  pll_state_t             pll_state_r;
  logic                   pll_lock;
  logic                   pll_wr;
  logic                   slow_prev_r;
  logic                   slow_rise;
  logic                   main_sel_r;
  logic [31:0]            irq_en_r;
  logic [31:0]            status;
  logic [31:0]            status_prev_r;
  logic [31:0]            events_r;
  logic [31:0]            fast_en_r;
  logic [31:0]            rdata_nxt;

  assign src_lvl   = {PLL_CLK_IN, MAIN_CLK_IN, SLOW_CLK_IN};
  assign pll_wr    = wr_hit(REG_WR_IN, REG_ADDR_IN, OFF_PLL_CONFIG);
  assign slow_rise = SLOW_CLK_IN & ~slow_prev_r;
  assign pll_lock  = (pll_state_r == PLL_LOCKED);

  // ****************************************************************
  // Clock configs and dividers
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_DIV; g++) begin : gen_div
      assign cfg_wr[g] = wr_hit(REG_WR_IN, REG_ADDR_IN, cfg_offset(g));

      always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          clk_cfg_r[g] <= CFG_RESET;
        end else if (cfg_wr[g]) begin
          clk_cfg_r[g] <= REG_WDATA_IN[CFG_W-1:0];
        end
      end

      clock_divider u_div (
        .clk_in     (CLK_SYS_IN),
        .rst_n_in   (RESET_N_IN),
        .src_lvl_in (src_lvl),
        .cfg_in     (clk_cfg_r[g]),
        .restart_in (cfg_wr[g]),
        .clk_out    (div_clk[g]),
        .ready_out  (div_ready[g])
      );
    end
  endgenerate

  assign MASTER_CLK_OUT        = div_clk[0];
  assign PROG_CLOCK_OUTPUT_OUT = div_clk[NUM_DIV-1:1];

  // ****************************************************************
  // PLL lock timer
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      slow_prev_r <= 1'b0;
    end else begin
      slow_prev_r <= SLOW_CLK_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pll_count_r <= '0;
      pll_wait_r  <= '0;
      pll_state_r <= PLL_IDLE;
    end else if (pll_wr) begin
      pll_count_r <= REG_WDATA_IN[PLL_COUNT_LSB +: PLL_COUNT_W];
      pll_wait_r  <= {REG_WDATA_IN[PLL_COUNT_LSB +: PLL_COUNT_W], 3'h0};
      pll_state_r <= PLL_COUNTING;
    end else begin
      case (pll_state_r)
        PLL_COUNTING: begin
          if (pll_wait_r == '0) begin
            pll_state_r <= PLL_LOCKED;
          end else if (slow_rise) begin
            pll_wait_r <= pll_wait_r - 9'h001;
          end
        end
        PLL_IDLE:   pll_state_r <= PLL_IDLE;
        PLL_LOCKED: pll_state_r <= PLL_LOCKED;
        default:    pll_state_r <= PLL_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Status
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      main_sel_r <= 1'b0;
    end else begin
      main_sel_r <= MAIN_SELECTION_DONE_IN;
    end
  end

  always_comb begin
    status                    = 32'h0000_0000;
    status[BIT_MAIN_READY]    = MAIN_CLOCK_READY_IN;
    status[BIT_PLL_LOCK]      = pll_lock;
    status[BIT_MASTER_READY]  = div_ready[0];
    status[BIT_PROG_READY0 +: NUM_PROG] = div_ready[NUM_DIV-1:1];
    status[BIT_MAIN_SEL_DONE] = main_sel_r;
  end

  // Sticky ready events, set wins over a clearing write
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      status_prev_r <= 32'h0000_0000;
      events_r      <= 32'h0000_0000;
    end else begin
      status_prev_r <= status;
      if (wr_hit(REG_WR_IN, REG_ADDR_IN, OFF_READY_EVENTS)) begin
        events_r <= ((events_r & ~REG_WDATA_IN) | (status & ~status_prev_r)) & IRQ_SRC_MASK;
      end else begin
        events_r <= (events_r | (status & ~status_prev_r)) & IRQ_SRC_MASK;
      end
    end
  end

  // ****************************************************************
  // Interrupt enables and output
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      irq_en_r <= 32'h0000_0000;
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, OFF_IRQ_ENABLE)) begin
      irq_en_r <= irq_en_r | (REG_WDATA_IN & IRQ_SRC_MASK);
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, OFF_IRQ_DISABLE)) begin
      irq_en_r <= irq_en_r & ~REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(status & irq_en_r & IRQ_SRC_MASK);
    end
  end

  // ****************************************************************
  // Fast start
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      fast_en_r        <= 32'h0000_0000;
      FAST_RESTART_OUT <= 1'b0;
    end else begin
      if (wr_hit(REG_WR_IN, REG_ADDR_IN, OFF_FAST_STARTUP_ENABLES)) begin
        fast_en_r <= REG_WDATA_IN & FAST_MASK;
      end
      FAST_RESTART_OUT <= |(WAKE_IN & fast_en_r[NUM_WAKE-1:0]);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (REG_ADDR_IN)
      OFF_PLL_CONFIG:           rdata_nxt[PLL_COUNT_LSB +: PLL_COUNT_W] = pll_count_r;
      OFF_CLOCK_STATUS:         rdata_nxt = status;
      OFF_IRQ_MASK_STATE:       rdata_nxt = ~irq_en_r & IRQ_SRC_MASK;
      OFF_FAST_STARTUP_ENABLES: rdata_nxt = fast_en_r;
      OFF_READY_EVENTS:         rdata_nxt = events_r;
      default:                  rdata_nxt = 32'h0000_0000;
    endcase
    for (int i = 0; i < NUM_DIV; i++) begin
      if (REG_ADDR_IN == cfg_offset(i)) begin
        rdata_nxt = {27'h0000000, clk_cfg_r[i]};
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT <= 32'h0000_0000;
    end else begin
      REG_RDATA_OUT <= REG_RD_IN ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  sequence rd_s(logic [7:0] off);
    REG_RD_IN && (REG_ADDR_IN == off);
  endsequence

  sequence wr_s(logic [7:0] off);
    REG_WR_IN && (REG_ADDR_IN == off);
  endsequence

  sequence mck_reserved_wr_s;
    wr_s(OFF_MASTER_CLOCK_CONFIG) ##0
      (REG_WDATA_IN[SOURCE_SEL_LSB +: SOURCE_SEL_W] == SRC_RESERVED);
  endsequence

  mask_polarity_a: assert property (
    rd_s(OFF_IRQ_MASK_STATE) |=> (REG_RDATA_OUT == (~$past(irq_en_r) & IRQ_SRC_MASK)))
    else $error("mask state polarity wrong");

  enable_sets_a: assert property (
    wr_s(OFF_IRQ_ENABLE) ##0 REG_WDATA_IN[BIT_PLL_LOCK] |=> irq_en_r[BIT_PLL_LOCK])
    else $error("enable write did not enable");

  disable_clears_a: assert property (
    wr_s(OFF_IRQ_DISABLE) |=> ((irq_en_r & $past(REG_WDATA_IN)) == 32'h0000_0000)
      && ((irq_en_r & ~$past(REG_WDATA_IN)) == ($past(irq_en_r) & ~$past(REG_WDATA_IN))))
    else $error("disable write wrong");

  status_read_a: assert property (
    rd_s(OFF_CLOCK_STATUS) |=> (REG_RDATA_OUT == $past(status))
      && (REG_RDATA_OUT[BIT_MAIN_READY] == $past(MAIN_CLOCK_READY_IN)))
    else $error("status read mismatch");

  irq_level_a: assert property (
    IRQ_OUT == $past(|(status & irq_en_r & IRQ_SRC_MASK)))
    else $error("interrupt level mismatch");

  pll_lock_time_a: assert property (
    $rose(pll_lock) |-> ($past(pll_wait_r) == '0) && ($past(pll_state_r) == PLL_COUNTING))
    else $error("PLL lock before count elapsed");

  pll_wr_unlock_a: assert property (
    wr_s(OFF_PLL_CONFIG) |=> !pll_lock)
    else $error("PLL lock kept after config write");

  mck_restart_a: assert property (
    wr_s(OFF_MASTER_CLOCK_CONFIG) |=> !status[BIT_MASTER_READY] [*2])
    else $error("master ready not cleared");

  mck_reserved_a: assert property (
    mck_reserved_wr_s ##1 (!REG_WR_IN [*8]) |-> !div_ready[0] && !MASTER_CLK_OUT)
    else $error("reserved source gave a clock");

  fast_start_a: assert property (
    FAST_RESTART_OUT == $past(|(WAKE_IN & fast_en_r[NUM_WAKE-1:0])))
    else $error("fast restart mismatch");

  prog_restart_a: assert property (
    (|cfg_wr[NUM_DIV-1:1]) |=> ((div_ready & $past(cfg_wr)) == '0))
    else $error("programmable ready not cleared");

  main_sel_a: assert property (
    status[BIT_MAIN_SEL_DONE] == $past(MAIN_SELECTION_DONE_IN))
    else $error("selection done status mismatch");

  pll_lock_hold_a: assert property (
    pll_lock && !pll_wr |=> pll_lock)
    else $error("PLL lock dropped without a write");

  fast_mask_a: assert property (
    wr_s(OFF_FAST_STARTUP_ENABLES) |=> (fast_en_r == ($past(REG_WDATA_IN) & FAST_MASK)))
    else $error("fast start enables not stored");

  event_clear_a: assert property (
    wr_s(OFF_READY_EVENTS) ##0 REG_WDATA_IN[BIT_PLL_LOCK]
      ##0 !(status[BIT_PLL_LOCK] && !status_prev_r[BIT_PLL_LOCK])
      |=> !events_r[BIT_PLL_LOCK])
    else $error("ready event not cleared");

  rdata_idle_a: assert property (
    !$past(REG_RD_IN) |-> (REG_RDATA_OUT == 32'h0000_0000))
    else $error("read data outside read slot");

endmodule : clock_select_status_irq

// ### sim/clock_select_status_irq_tb.sv
/*
 * Self-checking testbench for the clock select, status and interrupt block.
 * Assumes the package offsets and a DUT with its assertions built in;
 * the bench makes the three clock sources from the system clock.
 */
`timescale 1ns/1ps
module clock_select_status_irq_tb;
  import clock_select_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        slow_clk = 1'b0;
  logic        main_clk = 1'b0;
  logic        pll_clk = 1'b0;
  logic        main_rdy = 1'b0;
  logic        main_sel = 1'b0;
  logic [15:0] wake = 16'h0;
  logic        mclk;
  logic [2:0]  pclk;
  logic        fast;
  logic        irq;
  int          tick = 0;
  int          num_errors = 0;
  int          checked = 0;
  int          src_per[3] = '{10, 6, 4};
  int          t_sel[10] = '{0, 0, 0, 0, 0, 0, 1, 2, 3, 1};
  int          t_src[10] = '{0, 1, 2, 2, 0, 1, 1, 2, 0, 2};
  int          t_pre[10] = '{0, 0, 0, 3, 6, 1, 2, 4, 1, 5};

  clock_select_status_irq u_dut (
    .CLK_SYS_IN             (clk),
    .RESET_N_IN             (rst_n),
    .REG_ADDR_IN            (addr),
    .REG_WDATA_IN           (wdata),
    .REG_WR_IN              (wr),
    .REG_RD_IN              (rd),
    .REG_RDATA_OUT          (rdata),
    .SLOW_CLK_IN            (slow_clk),
    .MAIN_CLK_IN            (main_clk),
    .PLL_CLK_IN             (pll_clk),
    .MAIN_CLOCK_READY_IN    (main_rdy),
    .MAIN_SELECTION_DONE_IN (main_sel),
    .WAKE_IN                (wake),
    .MASTER_CLK_OUT         (mclk),
    .PROG_CLOCK_OUTPUT_OUT  (pclk),
    .FAST_RESTART_OUT       (fast),
    .IRQ_OUT                (irq)
  );

  // ****************************************************************
  // Clocks: sources with periods 10, 6 and 4 system cycles
  // ****************************************************************
  always #5 clk = ~clk;

  always @(posedge clk) begin
    tick     <= (tick == 59) ? 0 : tick + 1;
    slow_clk <= ((tick % 10) < 5);
    main_clk <= ((tick % 6) < 3);
    pll_clk  <= ((tick % 4) < 2);
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : reg_read

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_count(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_count

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_read(a, d);
    check_word($sformatf("register %h", a), exp, d);
  endtask : rd_chk

  task automatic wait_bit(input int b, input logic v, input int lim);
    logic [31:0] d;
    int          n;
    n = 0;
    do begin
      reg_read(8'h68, d);
      n++;
    end while (d[b] !== v && n < lim);
    check_word($sformatf("status bit %0d", b), {31'h0, v}, {31'h0, d[b]});
  endtask : wait_bit

  function automatic logic pick(input int s);
    return (s == 0) ? mclk : pclk[s-1];
  endfunction : pick

  // Cycles between two rising edges of a divided output
  task automatic measure(input int s, input int exp);
    int   n;
    int   e;
    int   t0;
    int   per;
    logic p;
    logic c;
    e = 0;
    t0 = 0;
    per = 0;
    p = pick(s);
    for (n = 0; n < 4000 && e < 3; n++) begin
      @(posedge clk);
      #1 c = pick(s);
      if (c === 1'b1 && p === 1'b0) begin
        if (e == 2) per = n - t0;
        t0 = n;
        e++;
      end
      p = c;
    end
    check_count($sformatf("period of output %0d", s), exp, per);
  endtask : measure

  task automatic end_sim;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    logic [31:0] cfg;
    int          i;
    int          s;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    rd_chk(8'h68, 32'h0000_0708);
    rd_chk(8'h6c, 32'h0000_070b);
    rd_chk(8'h30, 32'h0);
    rd_chk(8'h10, 32'h0);
    $display("test reset values done");
    reg_write(8'h60, 32'h0000_0001);
    rd_chk(8'h6c, 32'h0000_070a);
    check_word("irq", 32'h0, {31'h0, irq});
    reg_write(8'h60, 32'h0);
    rd_chk(8'h6c, 32'h0000_070a);
    main_rdy <= 1'b1;
    wait_bit(0, 1'b1, 2);
    repeat (2) @(posedge clk);
    check_word("irq", 32'h1, {31'h0, irq});
    reg_write(8'h64, 32'h0);
    rd_chk(8'h6c, 32'h0000_070a);
    reg_write(8'h64, 32'h0000_0001);
    rd_chk(8'h6c, 32'h0000_070b);
    repeat (2) @(posedge clk);
    check_word("irq", 32'h0, {31'h0, irq});
    main_rdy <= 1'b0;
    wait_bit(0, 1'b0, 2);
    $display("test interrupt enables done");
    for (i = 0; i < 10; i++) begin
      s = t_sel[i];
      cfg = {27'h0, t_pre[i][2:0], t_src[i][1:0]};
      reg_write((s == 0) ? 8'h30 : 8'h3c + 8'(4 * s), cfg);
      wait_bit((s == 0) ? 3 : 7 + s, 1'b0, 1);
      wait_bit((s == 0) ? 3 : 7 + s, 1'b1, 50);
      rd_chk((s == 0) ? 8'h30 : 8'h3c + 8'(4 * s), cfg);
      measure(s, src_per[t_src[i]] << t_pre[i]);
    end
    reg_write(8'h30, 32'h0000_0003);
    repeat (40) @(posedge clk);
    wait_bit(3, 1'b0, 1);
    reg_write(8'h48, 32'h0000_001c);
    repeat (40) @(posedge clk);
    wait_bit(10, 1'b0, 1);
    check_word("held clock", 32'h0, {31'h0, pclk[2]});
    $display("test clock selection done");
    reg_write(8'h74, 32'hffff_ffff);
    reg_write(8'h2c, 32'h0000_0200);
    wait_bit(1, 1'b0, 1);
    repeat (110) @(posedge clk);
    wait_bit(1, 1'b0, 1);
    wait_bit(1, 1'b1, 60);
    rd_chk(8'h2c, 32'h0000_0200);
    reg_read(8'h74, cfg);
    check_word("lock event", 32'h2, cfg & 32'h2);
    reg_write(8'h74, 32'h0000_0002);
    reg_read(8'h74, cfg);
    check_word("lock event cleared", 32'h0, cfg & 32'h2);
    reg_write(8'h60, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check_word("irq", 32'h1, {31'h0, irq});
    reg_write(8'h64, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check_word("irq", 32'h0, {31'h0, irq});
    $display("test pll lock done");
    reg_write(8'h70, 32'h0004_8004);
    rd_chk(8'h70, 32'h0000_8004);
    wake <= 16'h0008;
    repeat (3) @(posedge clk);
    check_word("fast restart", 32'h0, {31'h0, fast});
    wake <= 16'h0004;
    repeat (3) @(posedge clk);
    check_word("fast restart", 32'h1, {31'h0, fast});
    main_sel <= 1'b1;
    wait_bit(16, 1'b1, 2);
    reg_write(8'h68, 32'h0);
    rd_chk(8'h60, 32'h0);
    $display("test fast start done");
    end_sim();
  end

endmodule : clock_select_status_irq_tb
